// *** rtl/osfc_switch_fault_ctrl.sv ***
// Switch enable, switch state and diagnostic fault registers of a four-channel output switch,
// with a 16-bit serial register frame on its own link clock.
// Assumes fault conditions arrive as asynchronous pins and the host leaves a few sys_clk cycles between frames.
//
// Behaviour
// - Chain position 0 to 3 selects which frames this device answers.
// - Register 0x3 bits [3:0] hold the per-channel switch requests.
// - Register 0x3 bits [7:4] read back the actual switch states.
// - An enabled channel stays off under overheat, undervoltage, overload, link fault, gate low.
// - The channel turns on by itself once all inhibits clear; state follows.
// - Seven fault types are detected; link fault, overheat and field supply out of range shut all channels.
// - Overcurrent, overheat constraint, open load are recorded per channel; others device-wide.
// - Fault output is OR of recorded faults whose mask bit in 0x6 is set.
// - Fault bits record regardless of the mask.
// - With autoclear set in 0x7, a fault bit drops when its condition goes.
// - Without autoclear, a fault bit holds until a clear is written to 0x5.
// - One autoclear bit covers a channel fault type on all four channels.
// - Writing ones to 0x5 clears the matching recorded faults, several at once.
`timescale 1ns/1ns
module osfc_switch_fault_ctrl (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_mosi,
  output logic link_miso,
  output logic link_miso_oe_n,
  input wire osfc_pkg::osfc_pins_t pins,
  output logic [3:0] switch_out,
  output logic fault_output
);
  // Link domain: shift in a frame, hand it over by toggle.
  logic [4:0] bit_cnt;
  logic [osfc_pkg::FRAME_BITS-2:0] shift_in;
  osfc_pkg::osfc_frame_t frame_hold;
  logic req_tgl;
  logic [7:0] read_data;
  wire frame_end = (bit_cnt == osfc_pkg::FRAME_LAST);

  // The counter is reset by the frame select itself, since the link clock stops between frames.
  // Power-on reset clears it too, so the first frame after start-up is counted from zero.
  wire link_clear = link_cs_n | ~nrst;
  always_ff @(posedge link_sclk or posedge link_clear) begin
    if (link_clear) begin
      bit_cnt <= 5'h00;
    end else if (bit_cnt != osfc_pkg::FRAME_DONE) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge link_sclk or negedge nrst) begin
    if (!nrst) begin
      shift_in <= '0;
      frame_hold <= '0;
      req_tgl <= 1'b0;
    end else begin
      shift_in <= {shift_in[osfc_pkg::FRAME_BITS-3:0], link_mosi};
      if (frame_end && !link_cs_n) begin
        frame_hold <= {shift_in, link_mosi};
        req_tgl <= ~req_tgl;
      end
    end
  end

  // Read data is held stable in the sys domain from the previous read frame, so the
  // second byte of the next frame may sample it directly.
  wire [2:0] miso_idx = ~bit_cnt[2:0];
  wire in_data = (bit_cnt >= osfc_pkg::DATA_FIRST) && (bit_cnt <= osfc_pkg::FRAME_LAST);
  assign link_miso = in_data ? read_data[miso_idx] : 1'b0;
  assign link_miso_oe_n = link_cs_n;

  // Sys domain: synchronisers.
  logic [2:0] req_sync;
  osfc_pkg::osfc_pins_t pins_m;
  osfc_pkg::osfc_pins_t pins_s;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_sync <= 3'h0;
      pins_m <= '0;
      pins_s <= '0;
    end else begin
      req_sync <= {req_sync[1:0], req_tgl};
      pins_m <= pins;
      pins_s <= pins_m;
    end
  end

  wire frame_ev = req_sync[2] ^ req_sync[1];
  wire id_ok = (frame_hold.dev_id == pins_s.chain_position);
  wire wr_ev = frame_ev && frame_hold.write && id_ok;
  wire rd_ev = frame_ev && !frame_hold.write && id_ok;

  // Address decode.
  wire wr_switch = wr_ev && (frame_hold.addr == osfc_pkg::REG_SWITCH);
  wire wr_clear = wr_ev && (frame_hold.addr == osfc_pkg::REG_CLEAR);
  wire wr_mask = wr_ev && (frame_hold.addr == osfc_pkg::REG_MASK);
  wire wr_autoclr = wr_ev && (frame_hold.addr == osfc_pkg::REG_AUTOCLR);

  logic [3:0] switch_request;
  logic [3:0] switch_state;
  logic [7:0] fault_pin_mask;
  logic [7:0] autoclear_mask;
  logic [osfc_pkg::NUM_FAULTS-1:0] clear_pulse;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      switch_request <= osfc_pkg::SWITCH_RST;
      fault_pin_mask <= osfc_pkg::MASK_RST;
      autoclear_mask <= osfc_pkg::AUTOCLR_RST;
      clear_pulse <= '0;
    end else begin
      if (wr_switch) begin
        switch_request <= frame_hold.data[3:0];
      end
      if (wr_mask) begin
        fault_pin_mask <= frame_hold.data;
      end
      if (wr_autoclr) begin
        autoclear_mask <= frame_hold.data;
      end
      clear_pulse <= wr_clear ? frame_hold.data[osfc_pkg::NUM_FAULTS-1:0] : '0;
    end
  end

  // Fault conditions; device-wide first, then per-channel types.
  wire [osfc_pkg::NUM_DEV_FAULTS-1:0] cond_dev = {pins_s.field_supply_low_warning,
    pins_s.field_supply_out_of_range, pins_s.global_overheat_shutdown, pins_s.link_fault};
  wire [3:0] cond_ch [osfc_pkg::NUM_CH_FAULTS];
  assign cond_ch[0] = pins_s.overcurrent_shutdown;
  assign cond_ch[1] = pins_s.overheat_constraint;
  assign cond_ch[2] = pins_s.open_load_warning;

  logic [osfc_pkg::NUM_DEV_FAULTS-1:0] rec_dev;
  logic [3:0] rec_ch [osfc_pkg::NUM_CH_FAULTS];
  logic [osfc_pkg::NUM_FAULTS-1:0] fault_active;

  // Set wins over clear; autoclear drops the bit only once the condition has gone.
  function automatic logic [3:0] next_fault(input logic [3:0] rec, input logic [3:0] cond,
                                            input logic aclr, input logic clr);
    next_fault = cond | (rec & ~{4{clr}} & ~({4{aclr}} & ~cond));
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < osfc_pkg::NUM_DEV_FAULTS; gi++) begin : g_dev
      wire [3:0] next_rec = next_fault({3'h0, rec_dev[gi]}, {3'h0, cond_dev[gi]},
                                       autoclear_mask[gi], clear_pulse[gi]);
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          rec_dev[gi] <= 1'b0;
        end else begin
          rec_dev[gi] <= next_rec[0];
        end
      end
      assign fault_active[gi] = rec_dev[gi];
    end
    for (gi = 0; gi < osfc_pkg::NUM_CH_FAULTS; gi++) begin : g_ch
      localparam int IDX = osfc_pkg::FLT_OC + gi;
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          rec_ch[gi] <= 4'h0;
        end else begin
          rec_ch[gi] <= next_fault(rec_ch[gi], cond_ch[gi], autoclear_mask[IDX], clear_pulse[IDX]);
        end
      end
      assign fault_active[IDX] = |rec_ch[gi];
    end
  endgenerate

  // Channel inhibit and switch state.
  wire global_off = pins_s.global_overheat_shutdown | pins_s.logic_supply_low |
                    pins_s.field_supply_out_of_range | pins_s.link_fault | ~pins_s.output_gate;
  wire [3:0] inhibit = {4{global_off}} | pins_s.overcurrent_shutdown;
  wire [3:0] next_switch_state = switch_request & ~inhibit;
  wire next_fault_output = |(fault_pin_mask[osfc_pkg::NUM_FAULTS-1:0] & fault_active);

  function automatic logic [7:0] reg_read(input logic [4:0] addr);
    if (addr == osfc_pkg::REG_SWITCH) begin
      reg_read = {switch_state, switch_request};
    end else if (addr == osfc_pkg::REG_MASK) begin
      reg_read = fault_pin_mask;
    end else if (addr == osfc_pkg::REG_AUTOCLR) begin
      reg_read = autoclear_mask;
    end else if (addr == osfc_pkg::REG_DIAG_DEV) begin
      reg_read = {4'h0, rec_dev};
    end else if (addr == osfc_pkg::REG_DIAG_OC_OTC) begin
      reg_read = {rec_ch[1], rec_ch[0]};
    end else if (addr == osfc_pkg::REG_DIAG_OPEN) begin
      reg_read = {4'h0, rec_ch[2]};
    end else begin
      reg_read = osfc_pkg::UNMAPPED_READ;
    end
  endfunction

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      switch_state <= 4'h0;
      fault_output <= 1'b0;
      read_data <= 8'h00;
    end else begin
      switch_state <= next_switch_state;
      fault_output <= next_fault_output;
      if (rd_ev) begin
        read_data <= reg_read(frame_hold.addr);
      end
    end
  end

  assign switch_out = switch_state;

  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_mask_zero;
    (fault_pin_mask[osfc_pkg::NUM_FAULTS-1:0] == '0)[*2] |-> !fault_output;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("fault output with mask clear");

  property p_mask_pass;
    fault_pin_mask[osfc_pkg::FLT_OC] && (rec_ch[0] != 4'h0) |=> fault_output;
  endproperty
  a_mask_pass: assert property (p_mask_pass) else $error("masked-in fault not on output");

  property p_record_unmasked;
    pins_s.global_overheat_shutdown && !fault_pin_mask[osfc_pkg::FLT_OVERHEAT] |=> rec_dev[osfc_pkg::FLT_OVERHEAT];
  endproperty
  a_record_unmasked: assert property (p_record_unmasked) else $error("fault not recorded");

  property p_autoclear;
    autoclear_mask[osfc_pkg::FLT_LINK] && !pins_s.link_fault |=> !rec_dev[osfc_pkg::FLT_LINK];
  endproperty
  a_autoclear: assert property (p_autoclear) else $error("autoclear failed");

  property p_hold;
    rec_dev[osfc_pkg::FLT_OVERHEAT] && !autoclear_mask[osfc_pkg::FLT_OVERHEAT] &&
      !clear_pulse[osfc_pkg::FLT_OVERHEAT] |=> rec_dev[osfc_pkg::FLT_OVERHEAT];
  endproperty
  a_hold: assert property (p_hold) else $error("latched fault lost");

  property p_autoclear_ch;
    autoclear_mask[osfc_pkg::FLT_OPEN] && (pins_s.open_load_warning == 4'h0) |=> (rec_ch[2] == 4'h0);
  endproperty
  a_autoclear_ch: assert property (p_autoclear_ch) else $error("channel autoclear incomplete");

  property p_manual_clear;
    clear_pulse[osfc_pkg::FLT_OC] && (pins_s.overcurrent_shutdown == 4'h0) |=> (rec_ch[0] == 4'h0);
  endproperty
  a_manual_clear: assert property (p_manual_clear) else $error("manual clear failed");

  property p_clear_pulse;
    clear_pulse != '0 |=> clear_pulse == '0;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear held too long");

  property p_set_wins;
    pins_s.link_fault |=> rec_dev[osfc_pkg::FLT_LINK];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("present fault not set");

  property p_inhibit;
    inhibit[0] |=> !switch_state[0];
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibited channel on");

  property p_resume;
    (switch_request[0] && !inhibit[0])[*2] |-> switch_state[0];
  endproperty
  a_resume: assert property (p_resume) else $error("channel did not turn on");

  property p_shutdown_all;
    pins_s.link_fault |=> (switch_state == 4'h0);
  endproperty
  a_shutdown_all: assert property (p_shutdown_all) else $error("link fault left channel on");

  property p_switch_write;
    wr_switch |=> switch_request == frame_hold.data[3:0];
  endproperty
  a_switch_write: assert property (p_switch_write) else $error("switch request not stored");

  property p_other_id;
    frame_ev && frame_hold.write && !id_ok |=> $stable(fault_pin_mask) && $stable(switch_request);
  endproperty
  a_other_id: assert property (p_other_id) else $error("frame for other device taken");

  property p_req_hold;
    !wr_switch |=> $stable(switch_request);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("switch request changed without write");

  property p_read_switch;
    rd_ev && (frame_hold.addr == osfc_pkg::REG_SWITCH) |=> read_data == {$past(switch_state), $past(switch_request)};
  endproperty
  a_read_switch: assert property (p_read_switch) else $error("switch register read wrong");

  property p_gate_low;
    !pins_s.output_gate |=> switch_state == 4'h0;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("channel on with gate low");

  property p_overheat_all;
    pins_s.global_overheat_shutdown |=> switch_state == 4'h0;
  endproperty
  a_overheat_all: assert property (p_overheat_all) else $error("overheat left channel on");

  property p_otc_record;
    pins_s.overheat_constraint[0] |=> rec_ch[1][0];
  endproperty
  a_otc_record: assert property (p_otc_record) else $error("channel constraint fault not recorded");

  property p_open_record;
    pins_s.open_load_warning[3] |=> rec_ch[2][3];
  endproperty
  a_open_record: assert property (p_open_record) else $error("channel open load not recorded");

  property p_read_diag;
    rd_ev && (frame_hold.addr == osfc_pkg::REG_DIAG_DEV) |=> read_data == {4'h0, $past(rec_dev)};
  endproperty
  a_read_diag: assert property (p_read_diag) else $error("device fault read wrong");

  property p_mask_write;
    wr_mask |=> fault_pin_mask == frame_hold.data;
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("fault pin mask not stored");

  property p_autoclr_write;
    wr_autoclr |=> autoclear_mask == frame_hold.data;
  endproperty
  a_autoclr_write: assert property (p_autoclr_write) else $error("autoclear mask not stored");

  property p_clear_write;
    wr_clear |=> clear_pulse == frame_hold.data[osfc_pkg::NUM_FAULTS-1:0];
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("clear write not applied");

  c_channel_on: cover property (switch_request[0] ##[1:4] switch_state[0]);
  c_fault_pin: cover property (!fault_output ##1 fault_output);
  c_manual_clear: cover property (rec_dev[osfc_pkg::FLT_OVERHEAT] ##1 clear_pulse[osfc_pkg::FLT_OVERHEAT]);
  c_autoclear: cover property (rec_ch[2] != 4'h0 ##1 rec_ch[2] == 4'h0);
  c_other_id: cover property (frame_ev && !id_ok);
endmodule // osfc_switch_fault_ctrl

// *** rtl/osfc_pkg.sv ***
// Constants, register map and carrier types for the output switch fault control block.
// Assumes one device per chain position and a 5-bit address space of 8-bit registers reached over the serial link.
package osfc_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_FAULTS = 7;
  localparam int NUM_DEV_FAULTS = 4;
  localparam int NUM_CH_FAULTS = 3;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam logic [4:0] FRAME_DONE = 5'h10;
  localparam logic [4:0] DATA_FIRST = 5'h08;

  localparam logic [4:0] REG_DIAG_DEV = 5'h00;
  localparam logic [4:0] REG_DIAG_OC_OTC = 5'h01;
  localparam logic [4:0] REG_DIAG_OPEN = 5'h02;
  localparam logic [4:0] REG_SWITCH = 5'h03;
  localparam logic [4:0] REG_CLEAR = 5'h05;
  localparam logic [4:0] REG_MASK = 5'h06;
  localparam logic [4:0] REG_AUTOCLR = 5'h07;

  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] AUTOCLR_RST = 8'h00;
  localparam logic [3:0] SWITCH_RST = 4'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Fault type positions in mask, autoclear and clear registers.
  localparam int FLT_LINK = 0;
  localparam int FLT_OVERHEAT = 1;
  localparam int FLT_FIELD_RANGE = 2;
  localparam int FLT_FIELD_LOW = 3;
  localparam int FLT_OC = 4;
  localparam int FLT_OTC = 5;
  localparam int FLT_OPEN = 6;

  typedef struct packed {
    logic write;
    logic [1:0] dev_id;
    logic [4:0] addr;
    logic [7:0] data;
  } osfc_frame_t;

  typedef struct packed {
    logic [1:0] chain_position;
    logic output_gate;
    logic logic_supply_low;
    logic link_fault;
    logic global_overheat_shutdown;
    logic field_supply_out_of_range;
    logic field_supply_low_warning;
    logic [3:0] overcurrent_shutdown;
    logic [3:0] overheat_constraint;
    logic [3:0] open_load_warning;
  } osfc_pins_t;
endpackage

// *** bench/osfc_host_model.sv ***
// Serial host model that frames 16-bit register accesses for the fault control block.
// Assumes the link clock stands still between frames and the caller spaces frames on sys_clk.
`timescale 1ns/1ns
module osfc_host_model (
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_mosi,
  input wire logic link_miso,
  input wire logic link_miso_oe_n
);
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_mosi = 1'b0;
  end

  // The dev_id field carries the chain position of the addressed device.
  task automatic xfer(input logic [15:0] word, output logic [7:0] rdata);
    rdata = 8'h00;
    link_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      link_mosi = word[i];
      #3 link_sclk = 1'b1;
      #3 link_sclk = 1'b0;
      if (i >= 1 && i <= 8 && link_miso_oe_n == 1'b0) begin
        rdata[i-1] = link_miso;
      end
    end
    #3 link_cs_n = 1'b1;
    // A released line must not keep showing the last bit.
    link_mosi = ~link_mosi;
  endtask
endmodule // osfc_host_model

// *** bench/tb_output_switch_fault_control.sv ***
// Self-checking bench for the switch enable and fault register block.
// Assumes the wr and rd tasks space frames by six sys_clk cycles and pins settle within four.
`timescale 1ns/1ns
module tb_output_switch_fault_control;
  logic sys_clk, nrst, link_sclk, link_cs_n, link_mosi, link_miso, link_miso_oe_n, fault_output;
  osfc_pkg::osfc_pins_t pins;
  logic [3:0] switch_out, req, ch;
  logic [1:0] id;
  logic [7:0] rv, b;
  int err_count, n_tests, cyc;
  int fmap [7] = '{1, 2, 3, 6, 5, 7, 8};

  osfc_switch_fault_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .link_sclk(link_sclk), .link_cs_n(link_cs_n),
    .link_mosi(link_mosi), .link_miso(link_miso), .link_miso_oe_n(link_miso_oe_n), .pins(pins),
    .switch_out(switch_out), .fault_output(fault_output));
  osfc_host_model host (.link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_mosi(link_mosi),
    .link_miso(link_miso), .link_miso_oe_n(link_miso_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task wrap_up;
    $display("Checks run %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("mismatch at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task wait_sys(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.xfer({1'b1, id, a, d}, unused);
    wait_sys(6);
  endtask

  // Read data comes back on the frame after the one that asked for it.
  task rd(input logic [4:0] a, output logic [7:0] d);
    host.xfer({1'b0, id, a, 8'h00}, d);
    wait_sys(6);
    host.xfer({1'b0, id, a, 8'h00}, d);
    wait_sys(6);
  endtask

  task cond(input int k, input logic v);
    @(negedge sys_clk);
    case (k)
      0: pins.logic_supply_low = v;
      1: pins.link_fault = v;
      2: pins.global_overheat_shutdown = v;
      3: pins.field_supply_out_of_range = v;
      4: pins.output_gate = ~v;
      5: pins.overcurrent_shutdown = v ? ch : 4'h0;
      6: pins.field_supply_low_warning = v;
      7: pins.overheat_constraint = v ? ch : 4'h0;
      default: pins.open_load_warning = v ? ch : 4'h0;
    endcase
    wait_sys(4);
  endtask

  function automatic logic [4:0] diag_addr(input int t);
    return t < 4 ? osfc_pkg::REG_DIAG_DEV : (t == 6 ? osfc_pkg::REG_DIAG_OPEN : osfc_pkg::REG_DIAG_OC_OTC);
  endfunction

  function automatic logic [7:0] diag_val(input int t, input logic [3:0] c);
    return t < 4 ? 8'h01 << t : (t == 5 ? {c, 4'h0} : {4'h0, c});
  endfunction

  initial begin
    void'($urandom(32'ha22d));
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    nrst = 1'b0;
    pins = '0;
    pins.output_gate = 1'b1;
    pins.chain_position = 2'($urandom());
    id = pins.chain_position;
    wait_sys(5);
    nrst = 1'b1;
    wait_sys(3);
    chk({6'h0, link_miso_oe_n, link_miso}, 8'h02, "link released");
    rd(osfc_pkg::REG_MASK, rv); chk(rv, osfc_pkg::MASK_RST, "mask reset");
    rd(osfc_pkg::REG_AUTOCLR, rv); chk(rv, osfc_pkg::AUTOCLR_RST, "autoclear reset");
    rd(osfc_pkg::REG_SWITCH, rv); chk(rv, {2{osfc_pkg::SWITCH_RST}}, "switch reset");
    chk({7'h0, fault_output}, 8'h00, "fault output reset");
    rd(5'h1f, rv); chk(rv, osfc_pkg::UNMAPPED_READ, "unmapped read");
    rd(osfc_pkg::REG_CLEAR, rv); chk(rv, osfc_pkg::UNMAPPED_READ, "clear readback");
    rv = 8'($urandom());
    wr(osfc_pkg::REG_MASK, rv); rd(osfc_pkg::REG_MASK, b); chk(b, rv, "mask readback");
    wr(osfc_pkg::REG_MASK, 8'h00);
    req = 4'($urandom());
    wr(osfc_pkg::REG_SWITCH, {~req, req});
    chk({4'h0, switch_out}, {4'h0, req}, "switch request");
    rd(osfc_pkg::REG_SWITCH, rv); chk(rv, {req, req}, "switch state readback");
    id = id + 2'h1;
    wr(osfc_pkg::REG_SWITCH, {4'h0, ~req});
    id = id - 2'h1;
    chk({4'h0, switch_out}, {4'h0, req}, "other chain position");
    wr(osfc_pkg::REG_SWITCH, 8'h0f);
    ch = 4'($urandom_range(15, 1));
    for (int k = 0; k < 7; k++) begin
      cond(k, 1'b1);
      chk({4'h0, switch_out}, {4'h0, k == 5 ? ~ch : (k == 6 ? 4'hf : 4'h0)}, "inhibit");
      cond(k, 1'b0);
      chk({4'h0, switch_out}, 8'h0f, "inhibit gone");
    end
    wr(osfc_pkg::REG_CLEAR, 8'h7f);
    for (int a = 0; a < 3; a++) begin
      rd(5'(a), rv); chk(rv, 8'h00, "clear all");
    end
    for (int t = 0; t < 7; t++) begin
      ch = 4'($urandom_range(15, 1));
      b = 8'h01 << t;
      wr(osfc_pkg::REG_AUTOCLR, 8'h00);
      cond(fmap[t], 1'b1);
      chk({7'h0, fault_output}, 8'h00, "masked fault");
      rd(diag_addr(t), rv); chk(rv, diag_val(t, ch), "fault recorded");
      if (t < 2) chk({4'h0, switch_out}, 8'h00, "global shutdown");
      wr(osfc_pkg::REG_CLEAR, b);
      rd(diag_addr(t), rv); chk(rv, diag_val(t, ch), "set beats clear");
      wr(osfc_pkg::REG_MASK, b);
      chk({7'h0, fault_output}, 8'h01, "unmasked fault");
      cond(fmap[t], 1'b0);
      wr(osfc_pkg::REG_CLEAR, ~b);
      rd(diag_addr(t), rv); chk(rv, diag_val(t, ch), "latched fault");
      chk({7'h0, fault_output}, 8'h01, "latched fault output");
      wr(osfc_pkg::REG_CLEAR, b);
      rd(diag_addr(t), rv); chk(rv, 8'h00, "manual clear");
      chk({7'h0, fault_output}, 8'h00, "cleared fault output");
      wr(osfc_pkg::REG_AUTOCLR, b);
      cond(fmap[t], 1'b1);
      rd(diag_addr(t), rv); chk(rv, diag_val(t, ch), "autoclear set");
      cond(fmap[t], 1'b0);
      rd(diag_addr(t), rv); chk(rv, 8'h00, "autoclear");
    end
    wrap_up();
  end
endmodule // tb_output_switch_fault_control
